// [hw/reload_timer_defines.svh]
// Purpose: offsets, field positions, reset values and prescaler taps of the reload timer
// Assumes: 32-bit apb data, one aligned word per register
// Notes: definitions only
`ifndef RELOAD_TIMER_DEFINES_SVH
`define RELOAD_TIMER_DEFINES_SVH

`define RT_OFS_MODE 12'h000
`define RT_OFS_COUNT 12'h004
`define RT_OFS_IRQ_STATUS 12'h008
`define RT_OFS_IRQ_MASK 12'h00c
`define RT_MODE_RELOAD_BIT 7
`define RT_MODE_KEEP_BIT 6
`define RT_MODE_RESET 8'h78
`define RT_MODE_FIXED_ONES 8'h38
`define RT_CSEL_PROHIBITED 3'h7
`define RT_COUNT_RESET 8'h00
`define RT_COUNT_TOP 8'hff
`define RT_PRESCALE_WIDTH 13
`define RT_DIV_SEL0 14'h2000
`define RT_DIV_SEL1 14'h0800
`define RT_DIV_SEL2 14'h0200
`define RT_DIV_SEL3 14'h0100
`define RT_DIV_SEL4 14'h0040
`define RT_DIV_SEL5 14'h0010
`define RT_DIV_SEL6 14'h0004

`endif

// [hw/reload_timer_pkg.sv]
// Purpose: types shared by the reload timer
// Assumes: nothing beyond the defines header
// Notes: struct layout matches the mode register from bit 7 down
package reload_timer_pkg;
    typedef struct packed {
        logic reload_mode_select;
        logic keep_one;
        logic [2:0] fixed_ones;
        logic [2:0] clock_select;
    } timer_mode_s;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_SLEEP,
        PWR_SUBSLEEP,
        PWR_STANDBY
    } power_state_e;
endpackage

// [hw/interval_reload_timer8.sv]
// Purpose: 8-bit up-counting interval / auto-reload timer with overflow interrupt
// Assumes: apb slave, single clock, power state supplied by the system controller
// Notes: count reads and reload writes share one word
//
// Behaviour
// - 8-bit counter advances on each selected tick
// - select field picks one of seven divide taps
// - mode bit 7 chooses interval or reload
// - mode bits 5 to 3 read one
// - count readable anytime without disturbing counting
// - tick at ff overflows and sets flag
// - enabled flag raises the interrupt request
// - interval overflow returns counter to zero
// - reload write also loads the counter
// - reload mode overflow loads the reload value
// - reload write, count read share address
// - reset clears counter and mode bit
// - counter runs active, sleep; halts otherwise
// - mode register frozen outside active state
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "reload_timer_defines.svh"

module interval_reload_timer8 (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET,
    // power state from the system controller
    input wire reload_timer_pkg::power_state_e POWER_STATE,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // interrupt
    output logic IRQ
);
    localparam int PW = `RT_PRESCALE_WIDTH;

    logic [PW-1:0] prescale_q;
    logic [PW-1:0] prescale_d;
    logic [7:0] tap_rise;
    logic tick;
    logic run;
    logic [7:0] count_q;
    logic [7:0] reload_q;
    reload_timer_pkg::timer_mode_s mode_q;
    logic overflow_request_flag_q;
    logic overflow_interrupt_enable_q;
    logic overflow;
    logic access;
    logic wr;
    logic rd;
    logic hit_mode;
    logic hit_count;
    logic hit_stat;
    logic hit_mask;
    logic mapped;
    logic [31:0] rdata;

    // apb decode; every access completes one cycle after its first access phase cycle
    assign access = PSEL && PENABLE && !PREADY;
    assign wr = access && PWRITE;
    assign rd = access && !PWRITE;
    assign hit_mode = PADDR == `RT_OFS_MODE;
    assign hit_count = PADDR == `RT_OFS_COUNT;
    assign hit_stat = PADDR == `RT_OFS_IRQ_STATUS;
    assign hit_mask = PADDR == `RT_OFS_IRQ_MASK;
    assign mapped = hit_mode || hit_count || hit_stat || hit_mask;

    // counter halts in subsleep and standby
    assign run = (POWER_STATE == reload_timer_pkg::PWR_ACTIVE) ||
                 (POWER_STATE == reload_timer_pkg::PWR_SLEEP);

    // free-running prescaler, stopped with the counter to save power
    assign prescale_d = prescale_q + {{(PW-1){1'b0}}, 1'b1};
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            prescale_q <= '0;
        end else if (run) begin
            prescale_q <= prescale_d;
        end
    end

    // a tap ticks when its bit rises, giving a one-cycle enable per period
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_tap
            localparam int BITPOS = (g == 0) ? 12 : (g == 1) ? 10 : (g == 2) ? 8 :
                                    (g == 3) ? 7 : (g == 4) ? 5 : (g == 5) ? 3 : 1;
            if (g == 7) begin : g_none
                assign tap_rise[g] = 1'b0;
            end else begin : g_real
                assign tap_rise[g] = !prescale_q[BITPOS] && prescale_d[BITPOS];
            end
        end
    endgenerate

    // tap 0 divides by 8192 down to tap 6 by 4
    assign tick = run && tap_rise[mode_q.clock_select];
    assign overflow = tick && (count_q == `RT_COUNT_TOP);

    // counter: software load wins over a tick in the same cycle
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            count_q <= `RT_COUNT_RESET;
        end else if (wr && hit_count) begin
            count_q <= PWDATA[7:0];
        end else if (overflow) begin
            if (mode_q.reload_mode_select) begin
                count_q <= reload_q;
            end else begin
                count_q <= `RT_COUNT_RESET;
            end
        end else if (tick) begin
            count_q <= count_q + 8'h01;
        end
    end

    // reload value, write only
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            reload_q <= `RT_COUNT_RESET;
        end else if (wr && hit_count) begin
            reload_q <= PWDATA[7:0];
        end
    end

    // mode register; writes only take effect in the active state
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            mode_q <= `RT_MODE_RESET;
        end else if (wr && hit_mode && POWER_STATE == reload_timer_pkg::PWR_ACTIVE) begin
            mode_q.reload_mode_select <= PWDATA[`RT_MODE_RELOAD_BIT];
            mode_q.keep_one <= PWDATA[`RT_MODE_KEEP_BIT];
            mode_q.fixed_ones <= 3'h7;
            mode_q.clock_select <= PWDATA[2:0];
        end
    end

    // sticky overflow flag, write one clears; a new overflow beats the clear
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            overflow_request_flag_q <= 1'b0;
        end else if (overflow) begin
            overflow_request_flag_q <= 1'b1;
        end else if (wr && hit_stat && PWDATA[0]) begin
            overflow_request_flag_q <= 1'b0;
        end
    end

    // interrupt enable mask
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            overflow_interrupt_enable_q <= 1'b0;
        end else if (wr && hit_mask) begin
            overflow_interrupt_enable_q <= PWDATA[0];
        end
    end

    // level interrupt, registered so the output is a flop
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= overflow_request_flag_q && overflow_interrupt_enable_q;
        end
    end

    // read mux; count read never touches the counter
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit_mode) begin
            rdata = {24'h00_0000, mode_q | `RT_MODE_FIXED_ONES};
        end else if (hit_count) begin
            rdata = {24'h00_0000, count_q};
        end else if (hit_stat) begin
            rdata = {31'h0000_0000, overflow_request_flag_q};
        end else if (hit_mask) begin
            rdata = {31'h0000_0000, overflow_interrupt_enable_q};
        end
    end

    // apb answer: registered ready adds one wait cycle, error on unmapped address
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= access;
            PSLVERR <= access && !mapped;
            if (rd) begin
                PRDATA <= rdata;
            end
        end
    end

    // checks
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    count_step_a: assert property (tick && !(wr && hit_count) && count_q != 8'hff
        |=> count_q == $past(count_q) + 8'h01)
        else $error("counter did not advance on a tick");
    count_hold_a: assert property (!tick && !(wr && hit_count) |=> $stable(count_q))
        else $error("counter moved without a tick or load");
    no_tick_a: assert property (mode_q.clock_select == 3'h7 |-> !tick)
        else $error("tick with prohibited select");
    tap_four_a: assert property (mode_q.clock_select == 3'h6 && tick && run
        ##1 (mode_q.clock_select == 3'h6 && run) [*4] |-> tick)
        else $error("divide by four tap period wrong");
    ovf_flag_a: assert property (overflow |=> overflow_request_flag_q)
        else $error("overflow did not set flag");
    wrap_zero_a: assert property (overflow && !mode_q.reload_mode_select && !(wr && hit_count)
        |=> count_q == 8'h00)
        else $error("interval overflow not to zero");
    reload_ovf_a: assert property (overflow && mode_q.reload_mode_select && !(wr && hit_count)
        |=> count_q == $past(reload_q))
        else $error("auto reload value not loaded");
    load_now_a: assert property (wr && hit_count |=> count_q == $past(PWDATA[7:0])
        && reload_q == count_q)
        else $error("reload write did not load counter");
    irq_level_a: assert property (overflow_request_flag_q && overflow_interrupt_enable_q
        |=> IRQ)
        else $error("interrupt not raised");
    fixed_ones_a: assert property (rd && hit_mode |=> PRDATA[5:3] == 3'h7)
        else $error("reserved mode bits not one");
    halt_a: assert property (!run |-> !tick)
        else $error("tick while halted");
    mode_keep_a: assert property (POWER_STATE != reload_timer_pkg::PWR_ACTIVE
        |=> $stable(mode_q))
        else $error("mode changed outside active");

    // cycles since the previous tick, for a period check on every select
    logic [13:0] gap_q;
    logic [2:0] gap_sel_q;
    logic gap_valid_q;
    logic [13:0] gap_expect;

    // only whole periods under one select count; the first after a change may be short
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            gap_q <= 14'h0000;
            gap_sel_q <= 3'h0;
            gap_valid_q <= 1'b0;
        end else if (tick) begin
            gap_q <= 14'h0001;
            gap_sel_q <= mode_q.clock_select;
            gap_valid_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 14'h0001;
            if (!run || mode_q.clock_select != gap_sel_q) begin
                gap_valid_q <= 1'b0;
            end
        end
    end

    // expected tick spacing per select, prohibited code has none
    always_comb begin
        gap_expect = 14'h0000;
        unique case (gap_sel_q)
            3'h0: gap_expect = `RT_DIV_SEL0;
            3'h1: gap_expect = `RT_DIV_SEL1;
            3'h2: gap_expect = `RT_DIV_SEL2;
            3'h3: gap_expect = `RT_DIV_SEL3;
            3'h4: gap_expect = `RT_DIV_SEL4;
            3'h5: gap_expect = `RT_DIV_SEL5;
            3'h6: gap_expect = `RT_DIV_SEL6;
            3'h7: gap_expect = 14'h0000;
        endcase
    end

    // every whole period matches the selected divide ratio
    tap_period_a: assert property (
        tick && gap_valid_q && mode_q.clock_select == gap_sel_q
        |-> gap_q == gap_expect)
        else $error("tick period does not match select");

    // a tick never lasts two cycles
    tick_pulse_a: assert property (
        tick
        |=> !tick)
        else $error("tick longer than one cycle");

    // prescaler frozen while halted
    prescale_halt_a: assert property (
        !run
        |=> $stable(prescale_q))
        else $error("prescaler moved while halted");

    // flag stays set until software clears it
    flag_hold_a: assert property (
        overflow_request_flag_q && !(wr && hit_stat && PWDATA[0])
        |=> overflow_request_flag_q)
        else $error("overflow flag dropped on its own");

    // write one clears the flag when no overflow competes
    flag_clear_a: assert property (
        wr && hit_stat && PWDATA[0] && !overflow
        |=> !overflow_request_flag_q)
        else $error("overflow flag not cleared");

    // no interrupt without an enabled flag
    irq_quiet_a: assert property (
        !(overflow_request_flag_q && overflow_interrupt_enable_q)
        |=> !IRQ)
        else $error("interrupt without enabled flag");

    // count read returns the counter as it stood
    count_read_a: assert property (
        rd && hit_count
        |=> PRDATA == {24'h00_0000, $past(count_q)})
        else $error("count read value wrong");

    // reload value only changes by a write to the shared word
    reload_keep_a: assert property (
        !(wr && hit_count)
        |=> $stable(reload_q))
        else $error("reload value changed without a write");

    // mode bit follows an accepted write
    mode_bit_a: assert property (
        wr && hit_mode && POWER_STATE == reload_timer_pkg::PWR_ACTIVE
        |=> mode_q.reload_mode_select == $past(PWDATA[`RT_MODE_RELOAD_BIT]))
        else $error("mode bit not written");

    // every access phase is answered in the next cycle
    apb_answer_a: assert property (
        PSEL && PENABLE && !PREADY
        |=> PREADY)
        else $error("access not answered");

    // ready is a single-cycle pulse
    apb_pulse_a: assert property (
        PREADY
        |=> !PREADY)
        else $error("ready held too long");

    // unmapped addresses answer with an error
    apb_error_a: assert property (
        PSEL && PENABLE && !PREADY && !mapped
        |=> PSLVERR)
        else $error("no error on unmapped address");

    gap_full_c: cover property (tick && gap_valid_q && gap_sel_q == 3'h6);

    ovf_interval_c: cover property (overflow && !mode_q.reload_mode_select);
    ovf_reload_c: cover property (overflow && mode_q.reload_mode_select);
    irq_seen_c: cover property (IRQ);
    load_tick_c: cover property (wr && hit_count && tick);
endmodule

`default_nettype wire

// [dv/tb_top.sv]
// Purpose: self-checking bench for the interval / auto-reload timer
// Assumes: apb answers after one wait cycle, select 6 gives a tick every 4 cycles
// Notes: exact count checks are made when no tick can land: prescaler halted, select 7, or straight after reset
`timescale 1ns/1ps
`default_nettype none
`include "reload_timer_defines.svh"
module tb_top;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    reload_timer_pkg::power_state_e pwr = reload_timer_pkg::PWR_ACTIVE;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd, v;
    logic pready, pslverr, irq, err;
    int mismatches = 0;
    int check_count = 0;
    logic [31:0] seed = 32'd56218;

    // free-running system clock, 50 ns period
    always #25 clk_sys = ~clk_sys;

    interval_reload_timer8 i_interval_reload_timer8 (
        .CLK_SYS(clk_sys), .RESET(reset), .POWER_STATE(pwr),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .IRQ(irq)
    );

    // xorshift keeps the random stream repeatable
    function automatic logic [31:0] next_rand(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            mismatches++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // bounded wait for the interrupt line
    task automatic wait_irq();
        int n;
        for (n = 0; n < 400 && irq !== 1'b1; n++) @(posedge clk_sys);
        if (n == 400) begin
            mismatches++;
            final_report();
        end
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        apb(1'b0, `RT_OFS_MODE, 32'h0);
        check("mode reset", rd, 32'h78);
        apb(1'b0, `RT_OFS_COUNT, 32'h0);
        check("count reset", rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        $display("test reset done");
        // bit 6 kept at one by software, reserved bits written as zero
        apb(1'b1, `RT_OFS_MODE, 32'h46);
        apb(1'b0, `RT_OFS_MODE, 32'h0);
        check("mode rw", rd, 32'h7e);
        pwr <= reload_timer_pkg::PWR_STANDBY;
        apb(1'b1, `RT_OFS_MODE, 32'hc5);
        apb(1'b0, `RT_OFS_MODE, 32'h0);
        check("mode retained", rd, 32'h7e);
        // random reloads while halted must read back unchanged
        for (int i = 0; i < 6; i++) begin
            seed = next_rand(seed);
            v = {24'h0, seed[7:0]};
            pwr <= seed[8] ? reload_timer_pkg::PWR_STANDBY : reload_timer_pkg::PWR_SUBSLEEP;
            apb(1'b1, `RT_OFS_COUNT, v);
            repeat (20) @(posedge clk_sys);
            apb(1'b0, `RT_OFS_COUNT, 32'h0);
            check("halted count", rd, v);
        end
        pwr <= reload_timer_pkg::PWR_SLEEP;
        apb(1'b1, `RT_OFS_COUNT, 32'h0);
        repeat (40) @(posedge clk_sys);
        apb(1'b0, `RT_OFS_COUNT, 32'h0);
        check("tick rate", {31'h0, rd >= 9 && rd <= 13}, 32'h1);
        $display("test halt and rate done");
        pwr <= reload_timer_pkg::PWR_ACTIVE;
        apb(1'b1, `RT_OFS_MODE, 32'h47);
        apb(1'b1, `RT_OFS_COUNT, 32'h10);
        repeat (40) @(posedge clk_sys);
        apb(1'b0, `RT_OFS_COUNT, 32'h0);
        check("no tick select 7", rd, 32'h10);
        $display("test prohibited select done");
        // interval overflow with the interrupt unmasked
        apb(1'b1, `RT_OFS_IRQ_MASK, 32'h1);
        apb(1'b1, `RT_OFS_MODE, 32'h46);
        apb(1'b1, `RT_OFS_COUNT, 32'hfd);
        wait_irq();
        check("irq high", {31'h0, irq}, 32'h1);
        apb(1'b0, `RT_OFS_IRQ_STATUS, 32'h0);
        check("flag set", rd, 32'h1);
        apb(1'b0, `RT_OFS_COUNT, 32'h0);
        check("wrap to zero", {31'h0, rd < 32'h10}, 32'h1);
        apb(1'b1, `RT_OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk_sys);
        check("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, `RT_OFS_IRQ_STATUS, 32'h1);
        apb(1'b0, `RT_OFS_IRQ_STATUS, 32'h0);
        check("flag cleared", rd, 32'h0);
        $display("test interval irq done");
        // auto-reload from fe overflows every two ticks
        apb(1'b1, `RT_OFS_MODE, 32'hc6);
        apb(1'b1, `RT_OFS_COUNT, 32'hfe);
        apb(1'b1, `RT_OFS_IRQ_STATUS, 32'h1);
        apb(1'b1, `RT_OFS_IRQ_MASK, 32'h1);
        wait_irq();
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, `RT_OFS_COUNT, 32'h0);
            check("reload value", {31'h0, rd >= 32'hfe}, 32'h1);
        end
        $display("test auto reload done");
        final_report();
    end
endmodule
`default_nettype wire
